// ---- rtl/csl_consts.svh ----
`ifndef CSL_CONSTS_SVH
`define CSL_CONSTS_SVH

// ==========================================================
// register map (byte offsets)
`define CSL_CTRL_OFS      12'h000
`define CSL_HOLD_OFS      12'h004
`define CSL_STATUS_OFS    12'h008

// ==========================================================
// control fields
`define CSL_CTRL_HOME_BIT 0
`define CSL_CTRL_SRST_BIT 1
`define CSL_CTRL_RESET    1'b1

// ==========================================================
// status fields
`define CSL_ST_CALL_LSB   0
`define CSL_ST_POS_LSB    8
`define CSL_ST_UP_BIT     16
`define CSL_ST_DOWN_BIT   17
`define CSL_ST_BLOCK_BIT  18
`define CSL_ST_DOOR_BIT   19
`define CSL_ST_HOME_BIT   20

// ==========================================================
// timing
`define CSL_CLK_KHZ       125000
`define CSL_HOLD_TIME_MS  5000
`define CSL_POR_CYCLES    16

`endif

// ---- rtl/csl_pkg.sv ----
package csl_pkg;
  typedef logic [31:0] csl_word_t;
  typedef logic [11:0] csl_addr_t;
endpackage

// ---- rtl/csl_floor_unit.sv ----
`timescale 1ns/10ps
module csl_floor_unit #(
  parameter bit IS_BOTTOM = 1'b0,
  parameter bit IS_TOP    = 1'b0
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic call,
  input  wire logic block,
  input  wire logic greset,
  input  wire logic at_floor,
  input  wire logic at_floor_below,
  input  wire logic at_floor_above,
  input  wire logic cabin_below,
  input  wire logic cabin_above,
  output logic      call_mem,
  output logic      pos,
  output logic      up_req,
  output logic      down_req
);

  logic call_r;
  logic call_nxt;
  logic pos_mem_r;
  logic pos_mem_nxt;
  wire  new_call;

  // ==========================================================
  // call and position memories
  assign new_call    = call & ~block;
  // clearing wins here: a call at the floor where the cabin stands is served at once
  assign call_nxt    = (new_call | call_r) & ~pos & ~greset;
  assign pos_mem_nxt = (at_floor | pos_mem_r) & ~greset & ~at_floor_below
                       & ~at_floor_above;
  assign pos         = at_floor | pos_mem_r;
  assign call_mem    = call_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      call_r    <= 1'b0;
      pos_mem_r <= 1'b0;
    end else begin
      call_r    <= call_nxt;
      pos_mem_r <= pos_mem_nxt;
    end
  end

  // ==========================================================
  // direction requests; end floors drop the gate that cannot apply
  assign up_req   = IS_BOTTOM ? 1'b0 : (cabin_below & (call_r | new_call));
  assign down_req = IS_TOP    ? 1'b0 : (cabin_above & (call_r | new_call));

  a_call_latch: assert property (@(posedge clk) disable iff (rst)
    (call && !block && !pos && !greset) |=> call_r)
    else $error("call memory failed to latch");

  a_call_clear: assert property (@(posedge clk) disable iff (rst)
    (pos || greset) |=> !call_r)
    else $error("call memory not cleared");

  a_pos_mem: assert property (@(posedge clk) disable iff (rst)
    (at_floor && !greset && !at_floor_below && !at_floor_above) ##1 !at_floor_below
    && !at_floor_above && !greset |-> pos)
    else $error("position memory lost");

endmodule

// ---- rtl/csl_hold_timer.sv ----
`timescale 1ns/10ps
module csl_hold_timer (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        motion,
  input  wire logic [31:0] hold_cycles,
  output logic             busy
);

  logic        motion_r;
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  wire         fall;

  // ==========================================================
  // hold after the hoist command drops
  assign fall    = motion_r & ~motion;
  assign cnt_nxt = motion ? 32'h0 : fall ? hold_cycles :
                   (cnt_r != 32'h0) ? cnt_r - 32'h1 : 32'h0;
  assign busy    = motion | fall | (cnt_r != 32'h0);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      motion_r <= 1'b0;
      cnt_r    <= 32'h0;
    end else begin
      motion_r <= motion;
      cnt_r    <= cnt_nxt;
    end
  end

  a_hold_after_fall: assert property (@(posedge clk) disable iff (rst)
    ($fell(motion) && hold_cycles > 32'h2) |-> busy ##1 busy ##1 busy)
    else $error("hold interval ended early");

endmodule

// ---- rtl/csl_lift_top.sv ----
`timescale 1ns/10ps
`include "csl_consts.svh"
module csl_lift_top #(
  parameter int          FLOORS      = 4,
  parameter int unsigned HOLD_CYCLES = `CSL_HOLD_TIME_MS * `CSL_CLK_KHZ,
  parameter int          POR_CYCLES  = `CSL_POR_CYCLES
) (
  input  wire logic              CLK,
  input  wire logic              RST,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [11:0]       PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  input  wire logic [FLOORS-1:0] SHAFT_PROXIMITY_SENSOR_N,
  input  wire logic [FLOORS-1:0] CALL_BUTTON,
  input  wire logic [FLOORS-1:0] DOOR_CLOSED,
  input  wire logic              UPPER_LIMIT_N,
  input  wire logic              LOWER_LIMIT_N,
  output logic                   HOIST_UP,
  output logic                   HOIST_DOWN,
  output logic      [FLOORS-1:0] IN_USE_LAMP,
  output logic      [FLOORS-1:0] HERE_LAMP,
  output logic                   GONG_OUTPUT
);

  localparam int SW = 2 * FLOORS + 2;

  // ==========================================================
  // input synchronisers: sensors, buttons, door chain, limits
  logic [SW-1:0] sync1_r;
  logic [SW-1:0] sync2_r;
  wire  [SW-1:0] pins = {UPPER_LIMIT_N, LOWER_LIMIT_N, CALL_BUTTON,
                         SHAFT_PROXIMITY_SENSOR_N};
  // idle values: cabin nowhere, limits clear, no calls
  wire  [SW-1:0] idle = {2'b11, {FLOORS{1'b0}}, {FLOORS{1'b1}}};
  logic [FLOORS-1:0] door1_r;
  logic [FLOORS-1:0] door2_r;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sync1_r <= idle;
      sync2_r <= idle;
      door1_r <= '0;
      door2_r <= '0;
    end else begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
      door1_r <= DOOR_CLOSED;
      door2_r <= door1_r;
    end
  end

  wire [FLOORS-1:0] at_floor    = ~sync2_r[FLOORS-1:0];
  wire [FLOORS-1:0] call_s      = sync2_r[2*FLOORS-1:FLOORS];
  wire              lower_ok    = sync2_r[2*FLOORS];
  wire              upper_ok    = sync2_r[2*FLOORS+1];
  // contacts are in series: one open contact opens the chain
  wire              door_open   = ~&door2_r;

  // ==========================================================
  // general reset pulse after power-up or software request
  logic        por_r;
  logic [15:0] por_cnt_r;
  logic        srst_req;
  wire         greset = por_r;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      por_r     <= 1'b1;
      por_cnt_r <= 16'h0;
    end else if (srst_req) begin
      por_r     <= 1'b1;
      por_cnt_r <= 16'h0;
    end else if (por_r) begin
      por_cnt_r <= por_cnt_r + 16'h1;
      por_r     <= (por_cnt_r != 16'(POR_CYCLES - 1));
    end
  end

  // ==========================================================
  // floor units
  function automatic logic any_below(input logic [FLOORS-1:0] v, input int idx);
    logic r;
    r = 1'b0;
    for (int k = 0; k < FLOORS; k++) begin
      if (k < idx) r = r | v[k];
    end
    return r;
  endfunction

  function automatic logic any_above(input logic [FLOORS-1:0] v, input int idx);
    logic r;
    r = 1'b0;
    for (int k = 0; k < FLOORS; k++) begin
      if (k > idx) r = r | v[k];
    end
    return r;
  endfunction

  logic [FLOORS-1:0] pos;
  logic [FLOORS-1:0] call_mem;
  logic [FLOORS-1:0] up_req;
  logic [FLOORS-1:0] down_req;
  logic              block;

  for (genvar i = 0; i < FLOORS; i++) begin : g_floor
    csl_floor_unit #(
      .IS_BOTTOM (i == 0),
      .IS_TOP    (i == FLOORS - 1)
    ) u_floor (
      .clk            (CLK),
      .rst            (RST),
      .call           (call_s[i]),
      .block          (block),
      .greset         (greset),
      .at_floor       (at_floor[i]),
      .at_floor_below ((i > 0) ? at_floor[(i > 0) ? i - 1 : 0] : 1'b0),
      .at_floor_above ((i < FLOORS - 1) ? at_floor[(i < FLOORS - 1) ? i + 1 : i] : 1'b0),
      .cabin_below    (any_below(pos, i)),
      .cabin_above    (any_above(pos, i)),
      .call_mem       (call_mem[i]),
      .pos            (pos[i]),
      .up_req         (up_req[i]),
      .down_req       (down_req[i])
    );
  end

  // ==========================================================
  // hoist commands, homing and blocking
  logic up_r;
  logic down_r;
  logic homing_r;
  logic home_en_r;
  logic lamp_r;
  logic gong_r;
  logic hold_busy;
  logic [31:0] hold_r;

  // up has priority when both directions are wanted in one cycle
  wire up_nxt   = (|up_req) & upper_ok & ~door_open & ~down_r;
  wire down_nxt = ((|down_req) | homing_r) & lower_ok & ~door_open
                  & ~up_r & ~up_nxt;
  // set on the pulse wins over the bottom-floor clear
  wire homing_nxt = (greset & home_en_r) |
                    (homing_r & ~at_floor[0] & lower_ok);

  csl_hold_timer u_hold (
    .clk         (CLK),
    .rst         (RST),
    .motion      (up_r | down_r),
    .hold_cycles (hold_r),
    .busy        (hold_busy)
  );

  assign block = door_open | hold_busy;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      up_r     <= 1'b0;
      down_r   <= 1'b0;
      homing_r <= 1'b0;
      lamp_r   <= 1'b0;
      gong_r   <= 1'b0;
    end else begin
      up_r     <= up_nxt;
      down_r   <= down_nxt;
      homing_r <= homing_nxt;
      lamp_r   <= block;
      gong_r   <= (|call_s) & door_open;
    end
  end

  assign HOIST_UP    = up_r;
  assign HOIST_DOWN  = down_r;
  assign IN_USE_LAMP = {FLOORS{lamp_r}};
  assign HERE_LAMP   = pos;
  assign GONG_OUTPUT = gong_r;

  // ==========================================================
  // APB slave: no wait states, read data captured in the setup cycle, write data in the access cycle
  wire csl_pkg::csl_addr_t addr = PADDR;
  wire sel_ctrl   = (addr == `CSL_CTRL_OFS);
  wire sel_hold   = (addr == `CSL_HOLD_OFS);
  wire sel_status = (addr == `CSL_STATUS_OFS);
  wire mapped     = sel_ctrl | sel_hold | sel_status;
  wire setup      = PSEL & ~PENABLE;
  wire wr_acc     = PSEL & PENABLE & PWRITE & mapped;

  csl_pkg::csl_word_t status_w;
  always_comb begin
    status_w = '0;
    status_w[`CSL_ST_CALL_LSB +: FLOORS] = call_mem;
    status_w[`CSL_ST_POS_LSB +: FLOORS]  = pos;
    status_w[`CSL_ST_UP_BIT]             = up_r;
    status_w[`CSL_ST_DOWN_BIT]           = down_r;
    status_w[`CSL_ST_BLOCK_BIT]          = block;
    status_w[`CSL_ST_DOOR_BIT]           = door_open;
    status_w[`CSL_ST_HOME_BIT]           = homing_r;
  end

  wire csl_pkg::csl_word_t rd_w =
    sel_ctrl ? {31'h0, home_en_r} : sel_hold ? hold_r : sel_status ? status_w : 32'h0;

  assign srst_req = wr_acc & sel_ctrl & PWDATA[`CSL_CTRL_SRST_BIT];
  assign PREADY   = 1'b1;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PRDATA    <= 32'h0;
      PSLVERR   <= 1'b0;
      home_en_r <= `CSL_CTRL_RESET;
      hold_r    <= HOLD_CYCLES;
    end else begin
      if (setup) begin
        PRDATA  <= PWRITE ? 32'h0 : rd_w;
        PSLVERR <= ~mapped;
      end
      if (wr_acc && sel_ctrl) home_en_r <= PWDATA[`CSL_CTRL_HOME_BIT];
      if (wr_acc && sel_hold) hold_r <= PWDATA;
    end
  end

  // ==========================================================
  // checks
  a_hoist_interlock: assert property (@(posedge CLK) disable iff (RST)
    !(HOIST_UP && HOIST_DOWN))
    else $error("hoist up and down together");

  a_down_cause: assert property (@(posedge CLK) disable iff (RST)
    HOIST_DOWN |-> $past(lower_ok) && $past(!door_open) && $past(|down_req || homing_r))
    else $error("hoist down without cause");

  a_up_cause: assert property (@(posedge CLK) disable iff (RST)
    HOIST_UP |-> $past(upper_ok) && $past(!door_open) && $past(|up_req))
    else $error("hoist up without cause");

  a_block_door: assert property (@(posedge CLK) disable iff (RST)
    door_open |-> block ##1 IN_USE_LAMP == {FLOORS{1'b1}})
    else $error("door open did not block");

  a_lamp_follow: assert property (@(posedge CLK) disable iff (RST)
    !block ##1 !block |-> IN_USE_LAMP == '0)
    else $error("lamp lit while unblocked");

  a_gong_cause: assert property (@(posedge CLK) disable iff (RST)
    GONG_OUTPUT == $past(|call_s && door_open))
    else $error("gong does not match call and door");

  a_por_clears: assert property (@(posedge CLK) disable iff (RST)
    greset |=> call_mem == '0)
    else $error("general reset left a call stored");

  a_home_clear: assert property (@(posedge CLK) disable iff (RST)
    (homing_r && !greset && (at_floor[0] || !lower_ok)) |=> !homing_r)
    else $error("homing not cleared at bottom");

  a_homing_set: assert property (@(posedge CLK) disable iff (RST)
    (greset && home_en_r) |=> homing_r)
    else $error("homing not set by reset pulse");

  a_sense_invert: assert property (@(posedge CLK) disable iff (RST)
    !$past(RST) && !$past(RST, 2) |-> at_floor == ~$past(SHAFT_PROXIMITY_SENSOR_N, 2))
    else $error("at-floor is not the inverted sensor");

  a_end_gates: assert property (@(posedge CLK) disable iff (RST)
    !up_req[0] && !down_req[FLOORS-1])
    else $error("end floor raised an impossible request");

  a_motion_block: assert property (@(posedge CLK) disable iff (RST)
    (HOIST_UP || HOIST_DOWN) |-> block)
    else $error("cabin moving while unblocked");

  a_blocked_call: assert property (@(posedge CLK) disable iff (RST)
    (block && call_mem == '0) |=> call_mem == '0)
    else $error("call latched while blocked");

  a_stay_parked: assert property (@(posedge CLK) disable iff (RST)
    (!HOIST_UP && !HOIST_DOWN && !homing_r && call_mem == '0 && call_s == '0)
    |=> !HOIST_UP && !HOIST_DOWN)
    else $error("hoist started without a call");

endmodule

// ---- test/csl_shaft_model.sv ----
`timescale 1ns/10ps
// ==========================================================
// cabin in the shaft: one step per 8 cycles, floors two steps apart
module csl_shaft_model #(
  parameter int FLOORS = 4,
  parameter int START  = 0
) (
  input  wire logic              clk,
  input  wire logic              up,
  input  wire logic              down,
  output logic      [FLOORS-1:0] sensor_n,
  output logic                   upper_n,
  output logic                   lower_n
);
  int pos_r  = 2 * START;
  int tick_r = 0;

  // a step lands only every 8 cycles, so the hoist has time to stop at a floor
  always @(posedge clk) begin
    if (up != down) begin
      tick_r <= (tick_r == 7) ? 0 : tick_r + 1;
      if (tick_r == 7 && up && pos_r < 2 * (FLOORS - 1)) pos_r <= pos_r + 1;
      if (tick_r == 7 && down && pos_r > 0) pos_r <= pos_r - 1;
    end else begin
      tick_r <= 0;
    end
  end

  // between floors no detector sees the vane, so every output idles high
  always_comb begin
    for (int f = 0; f < FLOORS; f++) sensor_n[f] = (pos_r != 2 * f);
  end
  assign upper_n = (pos_r != 2 * (FLOORS - 1));
  assign lower_n = (pos_r != 0);
endmodule

// ---- test/call_send_lift_controller_bench.sv ----
`timescale 1ns/10ps
`include "csl_consts.svh"
module call_send_lift_controller_bench;
  localparam int FL   = 4;
  localparam int HOLD = 20;
  logic          CLK = 1'h0;
  logic          RST = 1'h1;
  logic          PSEL = 1'h0;
  logic          PENABLE = 1'h0;
  logic          PWRITE = 1'h0;
  logic [11:0]   PADDR = 12'h000;
  logic [31:0]   PWDATA = 32'h0;
  logic [31:0]   PRDATA;
  logic          PREADY;
  logic          PSLVERR;
  logic [FL-1:0] SENS_N;
  logic [FL-1:0] CALL_BUTTON = '0;
  logic [FL-1:0] DOOR_CLOSED = '1;
  logic          UPPER_LIMIT_N;
  logic          LOWER_LIMIT_N;
  logic          HOIST_UP;
  logic          HOIST_DOWN;
  logic [FL-1:0] IN_USE_LAMP;
  logic [FL-1:0] HERE_LAMP;
  logic          GONG_OUTPUT;
  int            fail_count = 0;
  int            checks_done = 0;
  int            cur = 2;
  int            tgt;
  logic [31:0]   q;
  logic          e;

  always #4 CLK = ~CLK;

  csl_lift_top #(.FLOORS(FL), .HOLD_CYCLES(16), .POR_CYCLES(4)) DUT (
    .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .SHAFT_PROXIMITY_SENSOR_N(SENS_N), .CALL_BUTTON(CALL_BUTTON),
    .DOOR_CLOSED(DOOR_CLOSED), .UPPER_LIMIT_N(UPPER_LIMIT_N),
    .LOWER_LIMIT_N(LOWER_LIMIT_N), .HOIST_UP(HOIST_UP), .HOIST_DOWN(HOIST_DOWN),
    .IN_USE_LAMP(IN_USE_LAMP), .HERE_LAMP(HERE_LAMP), .GONG_OUTPUT(GONG_OUTPUT));

  csl_shaft_model #(.FLOORS(FL), .START(2)) cabin (.clk(CLK), .up(HOIST_UP),
    .down(HOIST_DOWN), .sensor_n(SENS_N), .upper_n(UPPER_LIMIT_N), .lower_n(LOWER_LIMIT_N));

  // ==========================================================
  // helpers
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, x, s);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    PSEL <= 1'h1;
    PENABLE <= 1'h0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'h1;
    do @(posedge CLK); while (PREADY !== 1'h1);
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
    // one idle edge, so that a following call never drives psel twice in one step
    @(posedge CLK);
  endtask

  // 0..FL-1 here lamp, 8 up, 9 down, 10 gong, else hoist idle
  function automatic logic cond(input int k);
    if (k < FL) return HERE_LAMP[k];
    if (k == 8) return HOIST_UP;
    if (k == 9) return HOIST_DOWN;
    if (k == 10) return GONG_OUTPUT;
    return !(HOIST_UP || HOIST_DOWN);
  endfunction

  task automatic wt(input int k, input int lim);
    int n;
    n = 0;
    while (cond(k) !== 1'h1 && n < lim) begin
      @(posedge CLK);
      n++;
    end
    chk("wait", 32'(cond(k)), 32'h1);
  endtask

  function automatic logic [31:0] dir(input int from, input int to);
    return (to > from) ? 32'h2 : 32'h1;
  endfunction

  task automatic trip(input int t);
    int o;
    CALL_BUTTON[t] <= 1'h1;
    repeat (4) @(posedge CLK);
    CALL_BUTTON <= '0;
    wt(t > cur ? 8 : 9, 10);
    chk("dir", 32'({HOIST_UP, HOIST_DOWN}), dir(cur, t));
    repeat (2) @(posedge CLK);
    chk("inuse", 32'(IN_USE_LAMP), 32'hf);
    apb(1'h0, `CSL_STATUS_OFS, 32'h0);
    chk("mem", 32'(q[t]), 32'h1);
    // a second call during the run must be refused
    o = (t + 1 + $urandom_range(FL - 2)) % FL;
    CALL_BUTTON[o] <= 1'h1;
    repeat (4) @(posedge CLK);
    CALL_BUTTON <= '0;
    wt(t, 400);
    wt(11, 10);
    cur = t;
    chk("here", 32'(HERE_LAMP), 32'h1 << t);
    chk("busy", 32'(IN_USE_LAMP), 32'hf);
    // still held a few cycles before the interval ends, released well after it
    repeat (HOLD - 4) @(posedge CLK);
    chk("held", 32'(IN_USE_LAMP), 32'hf);
    repeat (12) @(posedge CLK);
    chk("idle", 32'(IN_USE_LAMP), 32'h0);
    apb(1'h0, `CSL_STATUS_OFS, 32'h0);
    chk("calls", 32'(q[7:0]), 32'h0);
    chk("pos", 32'(q[15:8]), 32'h1 << t);
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // watchdog
  initial begin
    #(8 * 40000);
    fail_count++;
    end_of_test;
  end

  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'hee7c));
    repeat (2) @(posedge CLK);
    RST <= 1'h0;
    wt(9, 30);
    wt(0, 200);
    wt(11, 10);
    cur = 0;
    apb(1'h0, `CSL_CTRL_OFS, 32'h0);
    chk("ctrl", q, 32'h1);
    apb(1'h0, `CSL_HOLD_OFS, 32'h0);
    chk("hold_rst", q, 32'h10);
    apb(1'h1, `CSL_HOLD_OFS, 32'(HOLD));
    apb(1'h0, `CSL_HOLD_OFS, 32'h0);
    chk("hold", q, 32'(HOLD));
    apb(1'h1, 12'h00c, 32'h5);
    chk("slverr", 32'(e), 32'h1);
    // the hold after homing must run out, or the first call would be refused
    repeat (HOLD + 8) @(posedge CLK);
    chk("idle0", 32'(IN_USE_LAMP), 32'h0);
    trip(3);
    for (int i = 0; i < 6; i++) begin
      do tgt = $urandom_range(FL - 1); while (tgt == cur);
      trip(tgt);
    end
    // door open: gong, no motion, call refused
    DOOR_CLOSED[1] <= 1'h0;
    repeat (4) @(posedge CLK);
    CALL_BUTTON[(cur + 1) % FL] <= 1'h1;
    wt(10, 8);
    chk("still", 32'({HOIST_UP, HOIST_DOWN}), 32'h0);
    apb(1'h0, `CSL_STATUS_OFS, 32'h0);
    chk("door", 32'(q[19]), 32'h1);
    CALL_BUTTON <= '0;
    repeat (4) @(posedge CLK);
    DOOR_CLOSED <= '1;
    repeat (10) @(posedge CLK);
    chk("nogong", 32'(GONG_OUTPUT), 32'h0);
    apb(1'h0, `CSL_STATUS_OFS, 32'h0);
    chk("blocked", 32'(q[7:0]), 32'h0);
    // fresh reset without and then with homing
    if (cur == 0) trip(2);
    // general reset while a stored call drives the hoist: call dropped, cabin parks
    tgt = (cur < 2) ? 3 : 0;
    CALL_BUTTON[tgt] <= 1'h1;
    repeat (4) @(posedge CLK);
    CALL_BUTTON <= '0;
    wt(tgt > cur ? 8 : 9, 10);
    apb(1'h1, `CSL_CTRL_OFS, 32'h2);
    repeat (30) @(posedge CLK);
    chk("parked", 32'({HOIST_UP, HOIST_DOWN}), 32'h0);
    chk("stay", 32'(HERE_LAMP), 32'h1 << cur);
    apb(1'h0, `CSL_STATUS_OFS, 32'h0);
    chk("cleared", 32'(q[7:0]), 32'h0);
    apb(1'h1, `CSL_CTRL_OFS, 32'h3);
    wt(9, 30);
    wt(0, 400);
    wt(11, 10);
    end_of_test;
  end
endmodule
